/* File: src/supply_reset_watchdog_supervisor.sv */
// top of the supply supervisor: threshold mode select, reset sequencing,
// early warning, chip-select gating, overvoltage flag and watchdog
// assumes analog comparator results arrive as clock-synchronous levels
//
// Functional notes
// (R1) threshold select high chooses external mode, low chooses internal mode
// (R2) external mode: warning uses early_power_fail_warn sense, reset uses threshold select input
// (R3) internal mode: falling supply gives warning no later than reset
// (R4) internal warning trips above reset threshold with hysteresis; high when supply good
// (R5) reset asserted while supply is below reset threshold
// (R6) reset asserted while manual reset input is low
// (R7) reset held a further 200 ms after manual reset released
// (R8) during reset counters clear, watchdog fault and pulse outputs high
// (R9) during reset chip-select path blocked, input floated, output high
// (R10) active-low reset and its exact inverse active-high reset
// (R11) overvoltage flag low when sense high; independent of all else
// (R12) kick level held past timeout asserts watchdog pulse and fault
// (R13) processor kicks each period; any edge or pulse restarts timer
// (R14) watchdog disabled while supply below reset threshold
// (R15) timeout select high uses default timeout, else alternative timeout
// (R16) watchdog fault stays low until the next kick transition
// (R17) watchdog pulse low at least 500 us, leading fault by about 70 ns
// (R18) manual reset driver holds it low at least 25 us
// (R19) chip select low at reset: pass it until high or 15 us
// (R20) timeouts and hold delay are clock cycle counts set by parameters
// (R21) comparators arrive synchronous; kick and manual reset synchronised first
`timescale 1ns/1ns
module supply_reset_watchdog_supervisor #(
  parameter int RESET_HOLD_CYC   = supervisor_pkg::RESET_HOLD_CYC,   // [R20]
  parameter int WDOG_DEFAULT_CYC = supervisor_pkg::WDOG_DEFAULT_CYC, // [R20]
  parameter int WDOG_ALT_CYC     = supervisor_pkg::WDOG_ALT_CYC,     // [R20]
  parameter int PULSE_LOW_CYC    = supervisor_pkg::PULSE_LOW_CYC     // [R20]
) (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // supply comparator results
  input  wire logic mode_select_ext_in,      // threshold select pin above 600 mV
  input  wire logic reset_sense_low_in,      // threshold select pin below its reference
  input  wire logic early_power_fail_warn_sense_input,     // early_power_fail_warn sense pin below its reference
  input  wire logic vcc_below_reset_int_in,  // supply below internal reset threshold
  input  wire logic vcc_below_warn_int_in,   // supply below internal warning threshold
  input  wire logic overvoltage_sense_in,    // overvoltage sense above 1.30 V
  // processor side inputs
  input  wire logic manual_reset_in,         // low asserts reset
  input  wire logic watchdog_kick_in,
  input  wire logic timeout_select_in,       // high selects default timeout
  input  wire logic chip_select_in,          // active low
  // reset outputs
  output logic      reset_n_out,
  output logic      reset_out,
  // warning and flag outputs
  output logic      early_power_fail_warn_out, // low warns
  output logic      overvoltage_flag_out,      // low flags overvoltage
  // watchdog outputs
  output logic      watchdog_fault_out,
  output logic      watchdog_pulse_out,
  // chip-select gate
  output logic      chip_select_out,
  output logic      chip_select_gate_on_out    // low floats the chip-select input
);

  wdog_if wd ();

  logic                                man_s1_reg,  man_s1_next;
  logic                                man_s2_reg,  man_s2_next;
  logic                                kick_s1_reg, kick_s1_next;
  logic                                kick_s2_reg, kick_s2_next;
  logic                                kick_s3_reg, kick_s3_next;
  supervisor_pkg::rst_state_t          state_reg,   state_next;
  logic [supervisor_pkg::HOLD_W-1:0]   hold_cnt_reg, hold_cnt_next;
  logic                                reset_reg,   reset_next;
  logic                                ce_hold_reg, ce_hold_next;
  logic [supervisor_pkg::CE_W-1:0]     ce_cnt_reg,  ce_cnt_next;
  logic                                warn_reg,    warn_next;
  logic                                ovf_reg,     ovf_next;
  logic                                supply_low;
  logic                                warn_low;
  logic                                kick_edge;
  logic                                gate_on;

  // input synchronisers; the second stage feeds the logic, and the kick third stage feeds the edge detect
  always_comb begin
    man_s1_next  = manual_reset_in;  // [R21]
    man_s2_next  = man_s1_reg;
    kick_s1_next = watchdog_kick_in; // [R21]
    kick_s2_next = kick_s1_reg;
    kick_s3_next = kick_s2_reg;
  end

  // synchroniser registers, released level for manual reset
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      man_s1_reg  <= 1'b1;
      man_s2_reg  <= 1'b1;
      kick_s1_reg <= 1'b0;
      kick_s2_reg <= 1'b0;
      kick_s3_reg <= 1'b0;
    end else begin
      man_s1_reg  <= man_s1_next;
      man_s2_reg  <= man_s2_next;
      kick_s1_reg <= kick_s1_next;
      kick_s2_reg <= kick_s2_next;
      kick_s3_reg <= kick_s3_next;
    end
  end

  // either transition counts, so a short pulse gives two kicks
  assign kick_edge = kick_s2_reg ^ kick_s3_reg; // [R13] [R21]

  // comparator selection by threshold mode
  assign supply_low = mode_select_ext_in ? reset_sense_low_in
                                         : vcc_below_reset_int_in; // [R1] [R2] [R5]
  // in internal mode below reset also counts as below warning, so warning never lags reset there
  assign warn_low   = mode_select_ext_in ? early_power_fail_warn_sense_input // [R2] [R3] [R4]
                                         : (vcc_below_warn_int_in | vcc_below_reset_int_in);

  // reset sequencer: held while a cause is present, then a fixed delay
  always_comb begin
    state_next    = state_reg;
    hold_cnt_next = hold_cnt_reg;
    if (supply_low || !man_s2_reg) begin // [R5] [R6]
      state_next    = supervisor_pkg::RS_HELD;
      hold_cnt_next = '0;
    end else begin
      case (state_reg)
        supervisor_pkg::RS_HELD: begin
          state_next    = supervisor_pkg::RS_DELAY;
          hold_cnt_next = '0;
        end
        supervisor_pkg::RS_DELAY: begin
          if (hold_cnt_reg == supervisor_pkg::HOLD_W'(RESET_HOLD_CYC - 1)) begin // [R7]
            state_next = supervisor_pkg::RS_RUN;
          end else begin
            hold_cnt_next = hold_cnt_reg + 1'b1;
          end
        end
        supervisor_pkg::RS_RUN: begin
          state_next = supervisor_pkg::RS_RUN;
        end
        default: begin
          state_next    = supervisor_pkg::RS_HELD;
          hold_cnt_next = '0;
        end
      endcase
    end
    reset_next = (state_next != supervisor_pkg::RS_RUN);
  end

  // sequencer registers; a power-on reset runs the full delay
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_reg    <= supervisor_pkg::RS_DELAY;
      hold_cnt_reg <= '0;
      reset_reg    <= supervisor_pkg::RESET_RST;
    end else begin
      state_reg    <= state_next;
      hold_cnt_reg <= hold_cnt_next;
      reset_reg    <= reset_next;
    end
  end

  // write-cycle completion window when reset catches chip select low
  always_comb begin
    ce_hold_next = ce_hold_reg;
    ce_cnt_next  = ce_cnt_reg;
    if (!reset_next) begin
      ce_hold_next = 1'b0;
      ce_cnt_next  = '0;
    end else if (!reset_reg) begin
      ce_hold_next = !chip_select_in; // [R19]
      ce_cnt_next  = '0;
    end else if (ce_hold_reg) begin
      if (chip_select_in ||
          ce_cnt_reg == supervisor_pkg::CE_W'(supervisor_pkg::CE_HOLD_CYC - 1)) begin // [R19]
        ce_hold_next = 1'b0;
      end else begin
        ce_cnt_next = ce_cnt_reg + 1'b1;
      end
    end
  end

  // completion window registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ce_hold_reg <= 1'b0;
      ce_cnt_reg  <= '0;
    end else begin
      ce_hold_reg <= ce_hold_next;
      ce_cnt_reg  <= ce_cnt_next;
    end
  end

  // warning and overvoltage flags
  always_comb begin
    warn_next = !warn_low;            // [R3] [R4]
    ovf_next  = !overvoltage_sense_in; // [R11]
  end

  // flag registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      warn_reg <= supervisor_pkg::WARN_RST;
      ovf_reg  <= supervisor_pkg::OVF_RST;
    end else begin
      warn_reg <= warn_next;
      ovf_reg  <= ovf_next;
    end
  end

  // watchdog hookup; reset already covers the low-supply case
  assign wd.rst_act     = reset_reg; // [R8] [R14]
  assign wd.kick_edge   = kick_edge;
  assign wd.timeout_cyc = timeout_select_in ? supervisor_pkg::CNT_W'(WDOG_DEFAULT_CYC)
                                            : supervisor_pkg::CNT_W'(WDOG_ALT_CYC); // [R15]

  wdog_timer #(
    .PULSE_CYC (PULSE_LOW_CYC),
    .LEAD_CYC  (supervisor_pkg::PULSE_LEAD_CYC)
  ) u_wdog (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .wd     (wd.timer)
  );

  // output drive; the chip-select path is a gate, not a register
  assign gate_on                   = !reset_reg || ce_hold_reg;          // [R9] [R19]
  assign chip_select_out           = gate_on ? chip_select_in : 1'b1;    // [R9]
  assign chip_select_gate_on_out   = gate_on;                            // [R9]
  assign reset_n_out               = !reset_reg;                         // [R10]
  assign reset_out                 = reset_reg;                          // [R10]
  assign early_power_fail_warn_out = warn_reg;
  assign overvoltage_flag_out      = ovf_reg;
  assign watchdog_fault_out        = wd.fault;
  assign watchdog_pulse_out        = wd.pulse;

  // the two reset outputs are always opposite
  property p_reset_pair;
    @(posedge clk_in) disable iff (rst_in)
      reset_out == !reset_n_out;
  endproperty
  a_reset_pair: assert property (p_reset_pair) else $error("reset outputs not inverse"); // [R10]

  // low supply in the selected mode asserts reset
  property p_supply_reset;
    @(posedge clk_in) disable iff (rst_in)
      supply_low |=> reset_out;
  endproperty
  a_supply_reset: assert property (p_supply_reset) else $error("low supply without reset"); // [R5]

  // external mode uses the threshold select pin for reset
  property p_ext_reset;
    @(posedge clk_in) disable iff (rst_in)
      (mode_select_ext_in && reset_sense_low_in) |=> reset_out;
  endproperty
  a_ext_reset: assert property (p_ext_reset) else $error("external reset sense ignored"); // [R2]

  // synchronised manual reset low asserts reset
  property p_manual_reset;
    @(posedge clk_in) disable iff (rst_in)
      !man_s2_reg |=> reset_out;
  endproperty
  a_manual_reset: assert property (p_manual_reset) else $error("manual reset ignored"); // [R6]

  // release only after the full hold count
  property p_hold_release;
    @(posedge clk_in) disable iff (rst_in)
      $fell(reset_reg) |->
        ($past(hold_cnt_reg) == supervisor_pkg::HOLD_W'(RESET_HOLD_CYC - 1));
  endproperty
  a_hold_release: assert property (p_hold_release) else $error("reset released early"); // [R7]

  // outside the completion window the chip-select output is high in reset
  property p_ce_block;
    @(posedge clk_in) disable iff (rst_in)
      (reset_reg && !ce_hold_reg) |-> (chip_select_out && !chip_select_gate_on_out);
  endproperty
  a_ce_block: assert property (p_ce_block) else $error("chip select not blocked"); // [R9]

  // completion window never outlasts its count
  property p_ce_window;
    @(posedge clk_in) disable iff (rst_in)
      ce_hold_reg |-> (ce_cnt_reg < supervisor_pkg::CE_W'(supervisor_pkg::CE_HOLD_CYC));
  endproperty
  a_ce_window: assert property (p_ce_window) else $error("chip select window too long"); // [R19]

  // in internal mode a low supply also drops the warning
  property p_warn_first;
    @(posedge clk_in) disable iff (rst_in)
      (!mode_select_ext_in && vcc_below_reset_int_in) |=> !early_power_fail_warn_out;
  endproperty
  a_warn_first: assert property (p_warn_first) else $error("reset without warning"); // [R3]

  // overvoltage flag follows its sense input only
  property p_ovf;
    @(posedge clk_in) disable iff (rst_in)
      overvoltage_sense_in |=> !overvoltage_flag_out;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overvoltage flag not low"); // [R11]

endmodule : supply_reset_watchdog_supervisor

/* File: src/supervisor_pkg.sv */
// constants, counts and state types for the supply supervisor with watchdog
// assumes a single 25 MHz clock; all other rates derive from it
package supervisor_pkg;

  // clock rate
  localparam int CLK_HZ  = 25_000_000;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;

  // documented durations in their own units
  localparam int RESET_HOLD_MS   = 200;
  localparam int WDOG_DEFAULT_MS = 1600;
  localparam int WDOG_ALT_MS     = 100;  // stand-in for the capacitor-set timeout
  localparam int PULSE_LOW_US    = 500;
  localparam int PULSE_LEAD_NS   = 70;
  localparam int CE_HOLD_US      = 15;

  // derived cycle counts: least times round up, longest times round down
  localparam int RESET_HOLD_CYC   = RESET_HOLD_MS * (CLK_HZ / 1000);
  localparam int WDOG_DEFAULT_CYC = WDOG_DEFAULT_MS * (CLK_HZ / 1000);
  localparam int WDOG_ALT_CYC     = WDOG_ALT_MS * (CLK_HZ / 1000);
  localparam int PULSE_LOW_CYC    = PULSE_LOW_US * CLK_MHZ;
  localparam int PULSE_LEAD_CYC   = (PULSE_LEAD_NS * CLK_MHZ + 999) / 1000;
  localparam int CE_HOLD_CYC      = CE_HOLD_US * CLK_MHZ;

  // counter widths
  localparam int CNT_W   = 26;
  localparam int HOLD_W  = 23;
  localparam int PULSE_W = 14;
  localparam int LEAD_W  = 2;
  localparam int CE_W    = 9;

  // values after reset
  localparam logic WARN_RST  = 1'b0;
  localparam logic OVF_RST   = 1'b1;
  localparam logic RESET_RST = 1'b1;

  // reset sequencer states
  typedef enum logic [1:0] {
    RS_HELD,
    RS_DELAY,
    RS_RUN
  } rst_state_t;

endpackage : supervisor_pkg

/* File: src/wdog_if.sv */
// signals between the supervisor core and its watchdog timer
// assumes both ends run on the same clock
`timescale 1ns/1ns
interface wdog_if;
  logic                           rst_act;
  logic                           kick_edge;
  logic [supervisor_pkg::CNT_W-1:0] timeout_cyc;
  logic                           fault;
  logic                           pulse;

  modport ctrl  (output rst_act, output kick_edge, output timeout_cyc,
                 input fault, input pulse);
  modport timer (input rst_act, input kick_edge, input timeout_cyc,
                 output fault, output pulse);
endinterface : wdog_if

/* File: src/wdog_timer.sv */
// watchdog timer: timeout counter, low pulse output and sticky fault output
// assumes kick_edge is already synchronised and one cycle per kick edge
`timescale 1ns/1ns
module wdog_timer #(
  parameter int PULSE_CYC = supervisor_pkg::PULSE_LOW_CYC,
  parameter int LEAD_CYC  = supervisor_pkg::PULSE_LEAD_CYC
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // link to the core
  wdog_if.timer    wd
);

  logic [supervisor_pkg::CNT_W-1:0]   cnt_reg,       cnt_next;
  logic [supervisor_pkg::PULSE_W-1:0] pulse_cnt_reg, pulse_cnt_next;
  logic [supervisor_pkg::LEAD_W-1:0]  lead_cnt_reg,  lead_cnt_next;
  logic                               fault_reg,     fault_next;
  logic                               pulse_reg,     pulse_next;

  // next state of the watchdog
  always_comb begin
    cnt_next       = cnt_reg;
    pulse_cnt_next = pulse_cnt_reg;
    lead_cnt_next  = lead_cnt_reg;
    fault_next     = fault_reg;
    pulse_next     = pulse_reg;
    if (wd.rst_act) begin // [R8] [R14]
      cnt_next       = '0;
      pulse_cnt_next = '0;
      lead_cnt_next  = '0;
      fault_next     = 1'b1;
      pulse_next     = 1'b1;
    end else begin
      // end of the low pulse
      if (pulse_cnt_reg != '0) begin
        pulse_cnt_next = pulse_cnt_reg - 1'b1;
        if (pulse_cnt_reg == supervisor_pkg::PULSE_W'(1)) begin
          pulse_next = 1'b1;
        end
      end
      // fault falls a short lead after the pulse
      if (lead_cnt_reg != '0) begin
        lead_cnt_next = lead_cnt_reg - 1'b1;
        if (lead_cnt_reg == supervisor_pkg::LEAD_W'(1) && !wd.kick_edge) begin
          fault_next = 1'b0; // [R12] [R17]
        end
      end
      if (wd.kick_edge) begin
        cnt_next   = '0;   // [R13]
        fault_next = 1'b1; // [R16]
      end else if (cnt_reg >= wd.timeout_cyc - 1'b1) begin
        cnt_next       = '0;
        pulse_next     = 1'b0; // [R12] [R17]
        pulse_cnt_next = supervisor_pkg::PULSE_W'(PULSE_CYC);
        lead_cnt_next  = supervisor_pkg::LEAD_W'(LEAD_CYC);
      end else begin
        cnt_next = cnt_reg + 1'b1;
      end
    end
  end

  // watchdog registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_reg       <= '0;
      pulse_cnt_reg <= '0;
      lead_cnt_reg  <= '0;
      fault_reg     <= 1'b1;
      pulse_reg     <= 1'b1;
    end else begin
      cnt_reg       <= cnt_next;
      pulse_cnt_reg <= pulse_cnt_next;
      lead_cnt_reg  <= lead_cnt_next;
      fault_reg     <= fault_next;
      pulse_reg     <= pulse_next;
    end
  end

  // outputs come straight from flip-flops
  assign wd.fault = fault_reg;
  assign wd.pulse = pulse_reg;

  // reset forces both outputs high
  property p_rst_high;
    @(posedge clk_in) disable iff (rst_in)
      wd.rst_act |=> (fault_reg && pulse_reg);
  endproperty
  a_rst_high: assert property (p_rst_high) else $error("watchdog outputs low under reset"); // [R8]

  // a kick edge restarts the counter
  property p_kick_restart;
    @(posedge clk_in) disable iff (rst_in)
      (wd.kick_edge && !wd.rst_act) |=> (cnt_reg == '0);
  endproperty
  a_kick_restart: assert property (p_kick_restart) else $error("kick did not restart"); // [R13]

  // fault follows the pulse by the lead
  property p_fault_lead;
    @(posedge clk_in) disable iff (rst_in)
      ($fell(pulse_reg) && fault_reg) ##1 (!wd.kick_edge && !wd.rst_act) [*2]
        |-> !fault_reg;
  endproperty
  a_fault_lead: assert property (p_fault_lead) else $error("fault did not follow pulse"); // [R17]

  // the low pulse is loaded with its full width
  property p_pulse_width;
    @(posedge clk_in) disable iff (rst_in)
      $fell(pulse_reg) |-> (pulse_cnt_reg == supervisor_pkg::PULSE_W'(PULSE_CYC));
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("pulse width not loaded"); // [R17]

  // fault stays low until a kick edge or reset
  property p_fault_sticky;
    @(posedge clk_in) disable iff (rst_in)
      (!fault_reg && !wd.kick_edge && !wd.rst_act) |=> !fault_reg;
  endproperty
  a_fault_sticky: assert property (p_fault_sticky) else $error("fault released early"); // [R16]

endmodule : wdog_timer

/* File: testbench/cpu_model.sv */
// processor stand-in: toggles the kick line and drives the manual reset line
// assumes the supervisor reset output is fed back so that kicking stalls under reset
`timescale 1ns/1ns
module cpu_model #(
  parameter int KICK_CYC   = 150,
  parameter int MAN_LOW_CYC = 700
) (
  // clock and supervisor reset
  input  wire logic clk_in,
  input  wire logic reset_in,
  // bench controls
  input  wire logic kick_en_in,
  input  wire logic man_go_in,
  // lines into the supervisor
  output logic      kick_out,
  output wire logic manual_reset_n_out
);
  int kick_cnt;
  int man_cnt;

  initial begin
    kick_out = 1'b0;
    kick_cnt = 0;
    man_cnt  = 0;
  end

  // one toggle each KICK_CYC cycles, well inside the default timeout
  always @(posedge clk_in) begin
    if (reset_in || !kick_en_in) begin
      kick_cnt <= 0;
    end else if (kick_cnt == KICK_CYC - 1) begin
      kick_cnt <= 0;
      kick_out <= ~kick_out;
    end else begin
      kick_cnt <= kick_cnt + 1;
    end
  end

  // manual reset held low 700 cycles, 28 us, just past the 25 us minimum press
  always @(posedge clk_in) begin
    if (man_go_in && man_cnt == 0) begin
      man_cnt <= MAN_LOW_CYC;
    end else if (man_cnt != 0) begin
      man_cnt <= man_cnt - 1;
    end
  end
  assign manual_reset_n_out = (man_cnt == 0);
endmodule : cpu_model

/* File: testbench/supply_reset_watchdog_supervisor_tb.sv */
// self-checking bench for the supply supervisor with watchdog
// assumes shortened hold and timeout counts; the processor model drives kick and manual reset
`timescale 1ns/1ns
module supply_reset_watchdog_supervisor_tb;
  localparam int HOLD = 20;
  localparam int TDEF = 200;
  localparam int TALT = 100;
  localparam int PLOW = 10;
  logic clk_in, rst_in, mode, rsl, lls, vbr, vbw, ovs, tsel, csi, kick_en, man_go;
  logic kick, man_n, rst_o, rst_n_o, warn, ovf, fault, pulse, cso, gate;
  int   fail_count, checks, n;

  supply_reset_watchdog_supervisor #(.RESET_HOLD_CYC(HOLD), .WDOG_DEFAULT_CYC(TDEF),
    .WDOG_ALT_CYC(TALT), .PULSE_LOW_CYC(PLOW)) supply_reset_watchdog_supervisor_inst (
    .clk_in(clk_in), .rst_in(rst_in), .mode_select_ext_in(mode), .reset_sense_low_in(rsl),
    .early_power_fail_warn_sense_input(lls), .vcc_below_reset_int_in(vbr), .vcc_below_warn_int_in(vbw),
    .overvoltage_sense_in(ovs), .manual_reset_in(man_n), .watchdog_kick_in(kick),
    .timeout_select_in(tsel), .chip_select_in(csi), .reset_n_out(rst_n_o),
    .reset_out(rst_o), .early_power_fail_warn_out(warn), .overvoltage_flag_out(ovf),
    .watchdog_fault_out(fault), .watchdog_pulse_out(pulse), .chip_select_out(cso),
    .chip_select_gate_on_out(gate));

  cpu_model cpu_model_inst (.clk_in(clk_in), .reset_in(rst_o), .kick_en_in(kick_en),
    .man_go_in(man_go), .kick_out(kick), .manual_reset_n_out(man_n));

  // 25 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  task automatic tick(input int k);
    repeat (k) begin
      @(posedge clk_in);
      #1;
    end
  endtask : tick

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish

  task automatic wait_release;
    n = 0;
    while (rst_o !== 1'b0 && n < 2000) begin
      tick(1);
      n++;
    end
    check(rst_o, 1'b0);
  endtask : wait_release

  task automatic hold_reset;
    rst_in = 1'b1;
    tick(4);
    check({rst_o, rst_n_o}, 2'b10);
    check({fault, pulse}, 2'b11);
    check({cso, gate}, 2'b10);
    check(ovf, 1'b1);
    rst_in = 1'b0;
    wait_release();
    check(n >= HOLD - 1 && n <= HOLD + 3, 1'b1);
  endtask : hold_reset

  task automatic t_internal;
    vbw = 1'b1;
    tick(3);
    check({warn, rst_o}, 2'b00);
    vbr = 1'b1;
    tick(2);
    check({warn, rst_o}, 2'b01);
    tick(TDEF + 50);
    check({fault, pulse}, 2'b11);
    vbr = 1'b0;
    vbw = 1'b0;
    tick(2);
    check({warn, rst_o}, 2'b11);
    wait_release();
  endtask : t_internal

  task automatic t_external;
    rsl = 1'b1;
    tick(3);
    check(rst_o, 1'b0);
    rsl = 1'b0;
    mode = 1'b1;
    vbr = 1'b1;
    vbw = 1'b1;
    tick(3);
    check({warn, rst_o}, 2'b10);
    lls = 1'b1;
    tick(2);
    check(warn, 1'b0);
    rsl = 1'b1;
    tick(2);
    check(rst_o, 1'b1);
    {rsl, lls, vbr, vbw} = 4'h0;
    tick(1);
    mode = 1'b0;
    wait_release();
  endtask : t_external

  task automatic t_overvoltage;
    ovs = 1'b1;
    tick(2);
    check({ovf, rst_o, warn}, 3'b001);
    ovs = 1'b0;
    tick(2);
    check(ovf, 1'b1);
  endtask : t_overvoltage

  task automatic t_manual;
    man_go = 1'b1;
    tick(1);
    man_go = 1'b0;
    tick(10);
    check(rst_o, 1'b1);
    tick(650);
    check(rst_o, 1'b1);
    n = 0;
    while (man_n !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    wait_release();
    check(n >= HOLD && n <= HOLD + 6, 1'b1);
  endtask : t_manual

  task automatic t_watchdog(input int t, input logic sel);
    tsel = sel;
    hold_reset();
    n = 0;
    while (pulse !== 1'b0 && n < 1000) begin
      tick(1);
      n++;
    end
    check(n >= t - 3 && n <= t + 3, 1'b1);
    n = 0;
    while (fault !== 1'b0 && n < 10) begin
      tick(1);
      n++;
    end
    check(n, 2);
    n = 0;
    while (pulse !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    check(n, PLOW - 2);
    tick(t);
    check(fault, 1'b0);
    kick_en = 1'b1;
    n = 0;
    while (fault !== 1'b1 && n < 300) begin
      tick(1);
      n++;
    end
    kick_en = 1'b0;
    check(n >= 150 && n <= 156, 1'b1);
  endtask : t_watchdog

  task automatic t_kicking;
    tick(1);
    kick_en = 1'b1;
    n = 0;
    repeat (3 * TDEF) begin
      tick(1);
      if ({fault, pulse} !== 2'b11) n++;
    end
    kick_en = 1'b0;
    check(n, 0);
  endtask : t_kicking

  task automatic t_chip_select;
    csi = 1'b0;
    tick(1);
    check({cso, gate}, 2'b01);
    vbr = 1'b1;
    n = 0;
    while (cso !== 1'b1 && n < 500) begin
      tick(1);
      n++;
    end
    check(n >= 372 && n <= 378, 1'b1);
    check(gate, 1'b0);
    vbr = 1'b0;
    wait_release();
    vbr = 1'b1;
    tick(50);
    check(cso, 1'b0);
    csi = 1'b1;
    tick(1);
    check({cso, gate}, 2'b10);
    csi = 1'b0;
    tick(2);
    check(cso, 1'b1);
    vbr = 1'b0;
    csi = 1'b1;
    wait_release();
  endtask : t_chip_select

  // main sequence
  initial begin
    {rst_in, mode, rsl, lls, vbr, vbw, ovs, csi, kick_en, man_go} = 10'h200;
    tsel = 1'b1;
    csi = 1'b1;
    fail_count = 0;
    checks = 0;
    hold_reset();
    t_internal();
    t_external();
    t_overvoltage();
    t_manual();
    t_chip_select();
    t_watchdog(TDEF, 1'b1);
    t_kicking();
    t_watchdog(TALT, 1'b0);
    tally_and_finish();
  end

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk_in);
    fail_count++;
    tally_and_finish();
  end
endmodule : supply_reset_watchdog_supervisor_tb
